// *** bench/tccu_pin_model.sv ***
// Model of the timer and the trigger pins that face the unit.
`timescale 1ns/1ps
`default_nettype none
module tccu_pin_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Commands from the bench.
    input wire logic i_run,
    input wire logic [tccu_pkg::TMR_W-1:0] i_load_val,
    input wire logic [tccu_pkg::NUM_CAP-1:0] i_pin_lvl,
    // Timer and pins toward the unit.
    output logic [tccu_pkg::TMR_W-1:0] o_timer_value,
    output logic o_timer_inc,
    output logic [tccu_pkg::NUM_CAP-1:0] o_trigger_pin
);
    logic [tccu_pkg::TMR_W-1:0] tv_q, tv_d;
    logic inc_q, inc_d;
    logic [tccu_pkg::NUM_CAP-1:0] pin_q, pin_d;
    // Timer steps by one with a pulse while running, else follows the load value.
    always_comb begin
        tv_d = i_run ? tv_q + 16'h0001 : i_load_val;
        inc_d = i_run;
        pin_d = i_pin_lvl;
    end
    // Registers that present the new count together with its pulse.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tv_q <= 16'h0000;
            inc_q <= 1'b0;
            pin_q <= 4'h0;
        end else begin
            tv_q <= tv_d;
            inc_q <= inc_d;
            pin_q <= pin_d;
        end
    end
    // Outputs.
    assign o_timer_value = tv_q;
    assign o_timer_inc = inc_q;
    assign o_trigger_pin = pin_q;
endmodule
`default_nettype wire

// *** bench/tccu_top_checker.sv ***
// Checker of port-level timing for the capture and compare unit.
`timescale 1ns/1ps
`default_nettype none
module tccu_top_checker (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Bus handshake.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic o_wb_ack,
    // Timer, pins and outputs.
    input wire logic i_timer_inc,
    input wire logic [tccu_pkg::NUM_CAP-1:0] i_trigger_pin,
    input wire logic [tccu_pkg::PORT_W-1:0] o_compare_output_port,
    input wire logic [tccu_pkg::NUM_CMP-1:0] o_compare_irq,
    input wire logic [tccu_pkg::NUM_CAP-1:0] o_trigger_event
);
    // A software write is the only cause of change besides a timer step.
    logic wr_req;
    assign wr_req = i_wb_cyc && i_wb_stb && i_wb_we;
    // All checks share one clock and the reset.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // Bus answers come one cycle after a request and last one cycle.
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("No acknowledge one cycle after a request.");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("Acknowledge held longer than one cycle.");
    // Port bits move at the second edge after a timer step, or with a write.
    a_port_hold: assert property (!$past(i_timer_inc) && !wr_req |=>
        $stable(o_compare_output_port))
        else $error("Port changed without a timer step or write.");
    a_toggle_hold: assert property (!$past(i_timer_inc) |=>
        $stable(o_compare_output_port[7:6]))
        else $error("Toggle bits changed without a timer step.");
    // An event needs a change of its pin one cycle earlier.
    a_event_cause: assert property (o_trigger_event != 4'h0 |->
        (o_trigger_event & ~($past(i_trigger_pin) ^ $past(i_trigger_pin, 2))) == 4'h0)
        else $error("Trigger event without a pin edge.");
    // Requests follow a match two edges on, and a write one or two edges on.
    a_irq_rise: assert property ((o_compare_irq & ~$past(o_compare_irq)) != 3'h0 |->
        $past(i_timer_inc, 2) || $past(wr_req, 2))
        else $error("Interrupt rose without a match or write.");
    a_irq_fall: assert property ((~o_compare_irq & $past(o_compare_irq)) != 3'h0 |->
        $past(wr_req) || $past(wr_req, 2))
        else $error("Interrupt fell without a write.");
    a_irq_hold: assert property (!$past(i_timer_inc) && !wr_req && !$past(wr_req) |=>
        $stable(o_compare_irq))
        else $error("Interrupt changed without a cause.");
endmodule
`default_nettype wire

// *** bench/test_timer_capture_compare_unit.sv ***
// Self-checking bench for the timer capture and compare unit.
`timescale 1ns/1ps
`default_nettype none
module test_timer_capture_compare_unit;
    // Bench signals toward the unit and the pin model.
    logic clk, arst_n, cyc, stb, we, ack, run, tinc, ev_clr;
    logic [7:0] adr, port;
    logic [3:0] sel, pin_lvl, pins, trig_ev, ev_seen;
    logic [2:0] irq;
    logic [15:0] tval, ld_val;
    logic [31:0] wdat, rdat;
    int err_count, total_checks, cycles;
    // Unit under test and its far side.
    tccu_top uut (.i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_timer_value(tval), .i_timer_inc(tinc), .i_trigger_pin(pins),
        .o_compare_output_port(port), .o_compare_irq(irq), .o_trigger_event(trig_ev));
    tccu_pin_model model (.i_clk(clk), .i_arst_n(arst_n), .i_run(run), .i_load_val(ld_val),
        .i_pin_lvl(pin_lvl), .o_timer_value(tval), .o_timer_inc(tinc), .o_trigger_pin(pins));
    // Clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Sticky record of trigger events, and the run-time ceiling.
    always @(posedge clk) begin
        ev_seen <= ev_clr ? 4'h0 : (ev_seen | trig_ev);
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic bus cycle, held until acknowledge is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Register write and checked register read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask
    // Sets one pin level together with the timer value, then lets it settle.
    task automatic step(input int c, input logic l, input logic [15:0] v);
        @(posedge clk);
        ld_val <= v;
        ev_clr <= 1'b0;
        pin_lvl <= l ? (pin_lvl | (4'h1 << c)) : (pin_lvl & ~(4'h1 << c));
        repeat (3) @(posedge clk);
    endtask
    // Gives exactly one timer step onto the value v.
    task automatic run_to(input logic [15:0] v);
        @(posedge clk);
        ld_val <= v - 16'h0001;
        repeat (2) @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Reset values, read-only and unmapped places.
    task automatic t_regs();
        rd(tccu_pkg::OFS_EDGE_CTRL, 32'h0000_0000);
        rd(tccu_pkg::OFS_PORT, 32'h0000_0000);
        wr(tccu_pkg::OFS_SET_EN, 32'h0000_00FF);
        rd(tccu_pkg::OFS_SET_EN, 32'h0000_003F);
        wr(tccu_pkg::OFS_CAP0, 32'h0000_1234);
        rd(tccu_pkg::OFS_CAP0, 32'h0000_0000);
        wr(8'hFC, 32'h0000_00A5);
        rd(8'hFC, 32'h0000_0000);
    endtask
    // Every channel in rising, falling and either-edge mode.
    task automatic t_capture();
        logic [15:0] e [4];
        logic [15:0] va;
        for (int c = 0; c < 4; c++) begin
            e[c] = 16'h0000;
        end
        for (int c = 0; c < 4; c++) begin
            for (int m = 1; m < 4; m++) begin
                va = 16'h1100 + 16'(16 * c + 2 * m);
                wr(tccu_pkg::OFS_EDGE_CTRL, 32'(m) << (2 * c));
                ev_clr <= 1'b1;
                step(c, 1'b1, va);
                if (m[0]) e[c] = va;
                rd(tccu_pkg::OFS_CAP0 + 8'(4 * c), {16'h0000, e[c]});
                step(c, 1'b0, va + 16'h0080);
                if (m[1]) e[c] = va + 16'h0080;
                rd(tccu_pkg::OFS_CAP0 + 8'(4 * c), {16'h0000, e[c]});
                chk({31'h0, ev_seen[c]}, 32'h0000_0001);
            end
        end
    endtask
    // Set, clear and toggle actions, flags, masking and the conflict case.
    task automatic t_compare();
        wr(tccu_pkg::OFS_CMP0, 32'h0000_0010);
        wr(tccu_pkg::OFS_CMP1, 32'h0000_0020);
        wr(tccu_pkg::OFS_CMP2, 32'h0000_0030);
        wr(tccu_pkg::OFS_SET_EN, 32'h0000_0015);
        wr(tccu_pkg::OFS_RST_TGL_EN, 32'h0000_0085);
        wr(tccu_pkg::OFS_IRQ_EN, 32'h0000_0010);
        run_to(16'h0010);
        chk({24'h00_0000, port}, 32'h0000_0015);
        chk({29'h0, irq}, 32'h0000_0001);
        rd(tccu_pkg::OFS_FLAGS, 32'h0000_0010);
        run_to(16'h0020);
        chk({24'h00_0000, port}, 32'h0000_0010);
        run_to(16'h0030);
        chk({24'h00_0000, port}, 32'h0000_0090);
        rd(tccu_pkg::OFS_SET_EN, 32'h0000_0095);
        rd(tccu_pkg::OFS_FLAGS, 32'h0000_0070);
        chk({29'h0, irq}, 32'h0000_0001);
        wr(tccu_pkg::OFS_FLAGS, 32'h0000_0070);
        rd(tccu_pkg::OFS_FLAGS, 32'h0000_0000);
        chk({29'h0, irq}, 32'h0000_0000);
        wr(tccu_pkg::OFS_RST_TGL_EN, 32'h0000_00C5);
        run_to(16'h0030);
        chk({24'h00_0000, port}, 32'h0000_0050);
        wr(tccu_pkg::OFS_CMP1, 32'h0000_0010);
        run_to(16'h0010);
        chk({24'h00_0000, port}, 32'h0000_0050);
        wr(tccu_pkg::OFS_PORT, 32'h0000_00FF);
        rd(tccu_pkg::OFS_PORT, 32'h0000_007F);
        chk({24'h00_0000, port}, 32'h0000_007F);
    endtask
    // Verdict and end of the run.
    task automatic wrap_up();
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        {cyc, stb, we, run, arst_n} = 5'h00;
        {adr, wdat, ld_val, pin_lvl} = 60'h0;
        sel = 4'hF;
        ev_clr = 1'b1;
        {err_count, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_capture();
        t_compare();
        wrap_up();
    end
endmodule
// Checker attached to every instance of the unit.
bind tccu_top tccu_top_checker u_chk (.i_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .o_wb_ack, .i_timer_inc, .i_trigger_pin, .o_compare_output_port, .o_compare_irq,
    .o_trigger_event);
`default_nettype wire

// *** inc/tccu_pkg.sv ***
// Package of constants shared by the timer capture and compare unit.
package tccu_pkg;

    // ---------------------------------------------------------------
    // Bus and data widths.
    // ---------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int TMR_W = 16;
    localparam int NUM_CAP = 4;
    localparam int NUM_CMP = 3;
    localparam int PORT_W = 8;

    // ---------------------------------------------------------------
    // Register byte offsets.
    // ---------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_EDGE_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_SET_EN = 8'h04;
    localparam logic [ADR_W-1:0] OFS_RST_TGL_EN = 8'h08;
    localparam logic [ADR_W-1:0] OFS_CMP0 = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_CMP1 = 8'h10;
    localparam logic [ADR_W-1:0] OFS_CMP2 = 8'h14;
    localparam logic [ADR_W-1:0] OFS_FLAGS = 8'h18;
    localparam logic [ADR_W-1:0] OFS_IRQ_EN = 8'h1C;
    localparam logic [ADR_W-1:0] OFS_CAP0 = 8'h20;
    localparam logic [ADR_W-1:0] OFS_CAP1 = 8'h24;
    localparam logic [ADR_W-1:0] OFS_CAP2 = 8'h28;
    localparam logic [ADR_W-1:0] OFS_CAP3 = 8'h2C;
    localparam logic [ADR_W-1:0] OFS_PORT = 8'h30;

    // ---------------------------------------------------------------
    // Field positions.
    // ---------------------------------------------------------------
    localparam int FLAG_LSB = 4;
    localparam int TGL_LO_BIT = 6;
    localparam int TGL_HI_BIT = 7;
    localparam int SR_W = 6;
    localparam int CMP_SET = 0;
    localparam int CMP_RST = 1;
    localparam int CMP_TGL = 2;

    // ---------------------------------------------------------------
    // Reset values.
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [TMR_W-1:0] RST_TMR = 16'h0000;
    localparam logic [DAT_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [PORT_W-1:0] RST_PORT = 8'h00;

    // Merges write data into a register under the byte enables.
    function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_v,
                                               input logic [DAT_W-1:0] new_v,
                                               input logic [SEL_W-1:0] sel);
        logic [DAT_W-1:0] res;
        res = old_v;
        for (int b = 0; b < SEL_W; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// *** logic/tccu_edge_detect.sv ***
// Edge qualifier for the four trigger pins of the capture unit.
`timescale 1ns/1ps
`default_nettype none

module tccu_edge_detect (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Pins and edge selection.
    input wire logic [tccu_pkg::NUM_CAP-1:0] i_trigger_pin,
    input wire logic [2*tccu_pkg::NUM_CAP-1:0] i_capture_edge_control,
    // Qualified edge events, one cycle each.
    output logic [tccu_pkg::NUM_CAP-1:0] o_event
);

    logic [tccu_pkg::NUM_CAP-1:0] pin_q;
    logic [tccu_pkg::NUM_CAP-1:0] pin_d;

    // ---------------------------------------------------------------
    // Edge qualification.
    // ---------------------------------------------------------------
    // Bit 2n selects rising, bit 2n+1 falling; both set capture either edge.
    always_comb begin
        pin_d = i_trigger_pin;
        for (int c = 0; c < tccu_pkg::NUM_CAP; c++) begin
            o_event[c] = (i_capture_edge_control[2*c] & i_trigger_pin[c] & ~pin_q[c])   // R1 R2 R3 R4 R17
                       | (i_capture_edge_control[2*c+1] & ~i_trigger_pin[c] & pin_q[c]); // R1 R2 R3 R4 R17
        end
    end

    // Holds the previous pin level for edge detection.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin_d;
        end
    end

endmodule

`default_nettype wire

// *** logic/tccu_top.sv ***
// Top of the timer capture and compare unit with its Wishbone register file.
//
// Behaviour
// R1 - Channel 3: bit7 falling, bit6 rising capture
// R2 - Channel 2: bit5 falling, bit4 rising capture
// R3 - Channel 1: bit3 falling, bit2 rising capture
// R4 - Channel 0: bit1 falling, bit0 rising capture
// R5 - Software loads compare values before enabling
// R6 - Compare new timer value on each increment
// R7 - Match flag set one cycle after match
// R8 - Flag requests interrupt only when enabled
// R9 - Compare 0 match sets enabled port bits
// R10 - Compare 1 match clears enabled port bits
// R11 - Compare 2 match toggles port bits 7, 6
// R12 - Toggle flops drive bits 7, 6, readable
// R13 - Zero enable bit disables that port action
// R14 - Each toggle flop obeys its own enable
// R15 - Capture loads full sixteen-bit timer value
// R16 - Edge selection also drives trigger interrupt events
// R17 - Both edge bits capture on either edge
// R18 - Same-cycle set and reset: reset wins
`timescale 1ns/1ps
`default_nettype none

module tccu_top (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Wishbone slave.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [tccu_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [tccu_pkg::SEL_W-1:0] i_wb_sel,
    input wire logic [tccu_pkg::DAT_W-1:0] i_wb_dat,
    output logic [tccu_pkg::DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // Timer.
    input wire logic [tccu_pkg::TMR_W-1:0] i_timer_value,
    input wire logic i_timer_inc,
    // Trigger pins.
    input wire logic [tccu_pkg::NUM_CAP-1:0] i_trigger_pin,
    // Outputs.
    output logic [tccu_pkg::PORT_W-1:0] o_compare_output_port,
    output logic [tccu_pkg::NUM_CMP-1:0] o_compare_irq,
    output logic [tccu_pkg::NUM_CAP-1:0] o_trigger_event
);

    // ---------------------------------------------------------------
    // Declarations.
    // ---------------------------------------------------------------
    // Bus, configuration, capture and compare state, each with its next value.
    logic ack_q, ack_d;
    logic [tccu_pkg::DAT_W-1:0] rdat_q, rdat_d;
    logic [7:0] edge_ctrl_q, edge_ctrl_d;
    logic [tccu_pkg::SR_W-1:0] set_en_q, set_en_d;
    logic [7:0] rst_tgl_en_q, rst_tgl_en_d;
    logic [tccu_pkg::TMR_W-1:0] cmp_q [tccu_pkg::NUM_CMP];
    logic [tccu_pkg::TMR_W-1:0] cmp_d [tccu_pkg::NUM_CMP];
    logic [tccu_pkg::TMR_W-1:0] cap_q [tccu_pkg::NUM_CAP];
    logic [tccu_pkg::TMR_W-1:0] cap_d [tccu_pkg::NUM_CAP];
    logic [tccu_pkg::NUM_CMP-1:0] flag_q, flag_d;
    logic [tccu_pkg::NUM_CMP-1:0] irq_en_q, irq_en_d;
    logic [tccu_pkg::NUM_CMP-1:0] match_q, match_d;
    logic [tccu_pkg::NUM_CMP-1:0] irq_q, irq_d;
    logic [tccu_pkg::PORT_W-1:0] port_q, port_d;
    logic [tccu_pkg::NUM_CAP-1:0] trig_q, trig_d;
    logic [tccu_pkg::NUM_CAP-1:0] cap_event;
    // Decoded write strobe, with the data and lanes that qualify it.
    logic wr_go;
    logic [tccu_pkg::DAT_W-1:0] wdat;
    logic [tccu_pkg::SEL_W-1:0] wsel;

    // ---------------------------------------------------------------
    // Trigger edge qualification.
    // ---------------------------------------------------------------
    // One edge detector serves both capture and trigger events.
    tccu_edge_detect u_edge (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_trigger_pin(i_trigger_pin),
        .i_capture_edge_control(edge_ctrl_q),
        .o_event(cap_event)
    );

    // ---------------------------------------------------------------
    // Bus handshake.
    // ---------------------------------------------------------------
    // Ack rises one cycle after the request and drops the cycle after.
    always_comb begin
        ack_d = i_wb_cyc & i_wb_stb & ~ack_q;
        // A write lands at the edge at which the master samples ack high.
        wr_go = i_wb_cyc & i_wb_stb & i_wb_we & ack_q;
        wdat = i_wb_dat;
        wsel = i_wb_sel;
        rdat_d = rdat_q;
        // The word is decoded when the request is first seen, so it stands with ack.
        if (ack_d && !i_wb_we) begin
            rdat_d = tccu_pkg::RST_WORD;
            case (i_wb_adr)
                tccu_pkg::OFS_EDGE_CTRL: rdat_d[7:0] = edge_ctrl_q;
                tccu_pkg::OFS_SET_EN: begin
                    rdat_d[tccu_pkg::SR_W-1:0] = set_en_q;
                    rdat_d[tccu_pkg::TGL_HI_BIT] = port_q[tccu_pkg::TGL_HI_BIT]; // R12
                    rdat_d[tccu_pkg::TGL_LO_BIT] = port_q[tccu_pkg::TGL_LO_BIT]; // R12
                end
                tccu_pkg::OFS_RST_TGL_EN: rdat_d[7:0] = rst_tgl_en_q;
                tccu_pkg::OFS_CMP0: rdat_d[tccu_pkg::TMR_W-1:0] = cmp_q[0];
                tccu_pkg::OFS_CMP1: rdat_d[tccu_pkg::TMR_W-1:0] = cmp_q[1];
                tccu_pkg::OFS_CMP2: rdat_d[tccu_pkg::TMR_W-1:0] = cmp_q[2];
                tccu_pkg::OFS_FLAGS: begin
                    rdat_d[tccu_pkg::FLAG_LSB +: tccu_pkg::NUM_CMP] = flag_q;
                end
                tccu_pkg::OFS_IRQ_EN: begin
                    rdat_d[tccu_pkg::FLAG_LSB +: tccu_pkg::NUM_CMP] = irq_en_q;
                end
                tccu_pkg::OFS_CAP0: rdat_d[tccu_pkg::TMR_W-1:0] = cap_q[0];
                tccu_pkg::OFS_CAP1: rdat_d[tccu_pkg::TMR_W-1:0] = cap_q[1];
                tccu_pkg::OFS_CAP2: rdat_d[tccu_pkg::TMR_W-1:0] = cap_q[2];
                tccu_pkg::OFS_CAP3: rdat_d[tccu_pkg::TMR_W-1:0] = cap_q[3];
                tccu_pkg::OFS_PORT: rdat_d[tccu_pkg::PORT_W-1:0] = port_q;
                // Unmapped places read as zero.
                default: rdat_d = tccu_pkg::RST_WORD;
            endcase
        end
    end

    // Registers the acknowledge and the read word; the word holds between reads.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q <= 1'b0;
            rdat_q <= tccu_pkg::RST_WORD;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers.
    // ---------------------------------------------------------------
    // Software writes land at the edge where the master sees ack.
    always_comb begin
        logic [tccu_pkg::DAT_W-1:0] tmp;
        tmp = tccu_pkg::RST_WORD;
        edge_ctrl_d = edge_ctrl_q;
        set_en_d = set_en_q;
        rst_tgl_en_d = rst_tgl_en_q;
        irq_en_d = irq_en_q;
        for (int i = 0; i < tccu_pkg::NUM_CMP; i++) begin
            cmp_d[i] = cmp_q[i];
        end
        // Capture words have no entry here, so writes to them are ignored.
        if (wr_go) begin
            case (i_wb_adr)
                tccu_pkg::OFS_EDGE_CTRL: begin
                    tmp = tccu_pkg::merge({24'h000000, edge_ctrl_q}, wdat, wsel);
                    edge_ctrl_d = tmp[7:0];
                end
                tccu_pkg::OFS_SET_EN: begin
                    tmp = tccu_pkg::merge({26'h0000000, set_en_q}, wdat, wsel);
                    set_en_d = tmp[tccu_pkg::SR_W-1:0];
                end
                tccu_pkg::OFS_RST_TGL_EN: begin
                    tmp = tccu_pkg::merge({24'h000000, rst_tgl_en_q}, wdat, wsel);
                    rst_tgl_en_d = tmp[7:0];
                end
                tccu_pkg::OFS_CMP0: begin
                    tmp = tccu_pkg::merge({16'h0000, cmp_q[0]}, wdat, wsel);
                    cmp_d[0] = tmp[tccu_pkg::TMR_W-1:0];
                end
                tccu_pkg::OFS_CMP1: begin
                    tmp = tccu_pkg::merge({16'h0000, cmp_q[1]}, wdat, wsel);
                    cmp_d[1] = tmp[tccu_pkg::TMR_W-1:0];
                end
                tccu_pkg::OFS_CMP2: begin
                    tmp = tccu_pkg::merge({16'h0000, cmp_q[2]}, wdat, wsel);
                    cmp_d[2] = tmp[tccu_pkg::TMR_W-1:0];
                end
                tccu_pkg::OFS_IRQ_EN: begin
                    // Only lane 0 carries the enable field.
                    if (wsel[0]) begin
                        irq_en_d = wdat[tccu_pkg::FLAG_LSB +: tccu_pkg::NUM_CMP];
                    end
                end
                default: tmp = tccu_pkg::RST_WORD;
            endcase
        end
    end

    // Registers the software-visible configuration.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            edge_ctrl_q <= tccu_pkg::RST_BYTE;
            set_en_q <= '0;
            rst_tgl_en_q <= tccu_pkg::RST_BYTE;
            irq_en_q <= '0;
            for (int i = 0; i < tccu_pkg::NUM_CMP; i++) begin
                cmp_q[i] <= tccu_pkg::RST_TMR;
            end
        end else begin
            edge_ctrl_q <= edge_ctrl_d;
            set_en_q <= set_en_d;
            rst_tgl_en_q <= rst_tgl_en_d;
            irq_en_q <= irq_en_d;
            for (int i = 0; i < tccu_pkg::NUM_CMP; i++) begin
                cmp_q[i] <= cmp_d[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // Capture channels.
    // ---------------------------------------------------------------
    // A qualified edge loads the whole timer value and pulses the event output.
    always_comb begin
        // A capture and its event come from the same qualified edge.
        trig_d = cap_event; // R16
        for (int c = 0; c < tccu_pkg::NUM_CAP; c++) begin
            cap_d[c] = cap_event[c] ? i_timer_value : cap_q[c]; // R15
        end
    end

    // Registers the capture words and the one-cycle event pulses.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            trig_q <= '0;
            for (int c = 0; c < tccu_pkg::NUM_CAP; c++) begin
                cap_q[c] <= tccu_pkg::RST_TMR;
            end
        end else begin
            trig_q <= trig_d;
            for (int c = 0; c < tccu_pkg::NUM_CAP; c++) begin
                cap_q[c] <= cap_d[c];
            end
        end
    end

    // ---------------------------------------------------------------
    // Compare channels, flags and port actions.
    // ---------------------------------------------------------------
    // The match is caught on the increment and acted on one cycle later.
    always_comb begin
        // Only a timer step starts a match, so a held timer value is ignored.
        for (int i = 0; i < tccu_pkg::NUM_CMP; i++) begin
            match_d[i] = i_timer_inc & (i_timer_value == cmp_q[i]); // R6
        end
        // Writing one clears a flag, but a new match in that cycle wins.
        flag_d = flag_q;
        if (wr_go && i_wb_adr == tccu_pkg::OFS_FLAGS && wsel[0]) begin
            flag_d = flag_q & ~wdat[tccu_pkg::FLAG_LSB +: tccu_pkg::NUM_CMP];
        end
        flag_d = flag_d | match_q; // R7
        // The request follows the next flag value, so it rises with the flag.
        irq_d = flag_d & irq_en_q; // R8
        // Software may write the plain latch bits; compare actions override.
        port_d = port_q;
        if (wr_go && i_wb_adr == tccu_pkg::OFS_PORT && wsel[0]) begin
            port_d[tccu_pkg::SR_W-1:0] = wdat[tccu_pkg::SR_W-1:0];
        end
        if (match_q[tccu_pkg::CMP_SET]) begin
            port_d[tccu_pkg::SR_W-1:0] = port_d[tccu_pkg::SR_W-1:0] | set_en_q; // R9 R13
        end
        // The clear follows the set, so a same-cycle clear wins.
        if (match_q[tccu_pkg::CMP_RST]) begin
            port_d[tccu_pkg::SR_W-1:0] = port_d[tccu_pkg::SR_W-1:0]
                                       & ~rst_tgl_en_q[tccu_pkg::SR_W-1:0]; // R10 R13 R18
        end
        // Toggle bits change only through their flops, never by a port write.
        if (match_q[tccu_pkg::CMP_TGL]) begin
            port_d[tccu_pkg::TGL_HI_BIT] = port_q[tccu_pkg::TGL_HI_BIT]
                                         ^ rst_tgl_en_q[tccu_pkg::TGL_HI_BIT]; // R11 R12 R14
            port_d[tccu_pkg::TGL_LO_BIT] = port_q[tccu_pkg::TGL_LO_BIT]
                                         ^ rst_tgl_en_q[tccu_pkg::TGL_LO_BIT]; // R11 R12 R14
        end
    end

    // Registers matches, flags, interrupt requests and the port.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            match_q <= '0;
            flag_q <= '0;
            irq_q <= '0;
            port_q <= tccu_pkg::RST_PORT;
        end else begin
            match_q <= match_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
            port_q <= port_d;
        end
    end

    // ---------------------------------------------------------------
    // Output assignments.
    // ---------------------------------------------------------------
    // Every output is a flip-flop.
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_compare_output_port = port_q;
    assign o_compare_irq = irq_q;
    assign o_trigger_event = trig_q;

endmodule

`default_nettype wire
